/* ltp_pkg.sv */
// Constants, commands and carriers of the LED thermal/PWM register set.
// Assumes a single 25 MHz clock shared by every user of this package.
package ltp_pkg;

    // Clock and derived rates
    localparam int CLK_HZ         = 25_000_000;
    localparam int SENS_FAST_HZ   = 19_200;
    localparam int SENS_SLOW_HZ   = 2_400;
    localparam int SENS_FAST_CYC  = CLK_HZ / SENS_FAST_HZ;
    localparam int SENS_SLOW_CYC  = CLK_HZ / SENS_SLOW_HZ;
    localparam int PWM_LO_HZ      = 586;
    localparam int PWM_HI_HZ      = 1172;
    localparam int PWM_LO_BITS    = 15;
    localparam int PWM_HI_BITS    = 14;
    localparam int PWM_TICK_RAW   = CLK_HZ / (PWM_LO_HZ * (2 ** PWM_LO_BITS));
    localparam int PWM_TICK_CYC   = (PWM_TICK_RAW < 1) ? 1 : PWM_TICK_RAW;

    // Setup byte fields
    localparam int SB_PWMF        = 7;
    localparam int SB_CLKINV      = 6;
    localparam int SB_CRCEN       = 5;
    localparam int SB_RATE        = 4;
    localparam int SB_CESLP       = 3;
    localparam int SB_LOSSLP      = 2;
    localparam int SB_OTSLP       = 1;
    localparam int SB_UVSLP       = 0;
    localparam logic [7:0] SETUP_RST = 8'h13;

    // Threshold word fields
    localparam int TH_FILT_LSB    = 20;
    localparam int TH_REL_LSB     = 8;
    localparam int TH_TRIP_LSB    = 0;
    localparam logic [23:0] TH_MASK = 24'h30FFFF;
    localparam logic [23:0] TH_RST  = 24'h30E6F0;

    // Channel word fields
    localparam int CH_RED_LSB     = 32;
    localparam int CH_GRN_LSB     = 16;
    localparam int CH_BLU_LSB     = 0;
    localparam int CH_ISEL        = 15;
    localparam logic [47:0] CH_RST = 48'h000000000000;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_READ_HEAT,
        CMD_READ_OVERHEAT_LIMITS,
        CMD_WRITE_OVERHEAT_LIMITS,
        CMD_READ_CONFIG_BYTE,
        CMD_WRITE_CONFIG_BYTE,
        CMD_READ_CHANNEL_WORD,
        CMD_WRITE_CHANNEL_WORD
    } ltp_cmd_code_t;

    typedef struct packed {
        logic          valid;
        ltp_cmd_code_t code;
        logic [47:0]   data;
    } ltp_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [47:0] data;
    } ltp_resp_t;

    typedef struct packed {
        logic comm;
        logic led;
        logic uv;
    } ltp_faults_t;

endpackage : ltp_pkg

/* ltp_pwm_chan.sv */
// One colour channel: duty compare against the shared modulation counter.
// Assumes the counter and mode bit come from the same clock domain.
`timescale 1ns/1ps
module ltp_pwm_chan (
    input  wire logic        clk,     // 25 MHz clock
    input  wire logic        rst_n,   // Async reset, active low
    input  wire logic        hiFreq,  // 14-bit fast mode
    input  wire logic [14:0] count,   // Shared period counter
    input  wire logic [14:0] duty,    // Duty value from channel word
    output logic             pwmOut   // Registered drive level
);

    logic pwm_r;
    logic pwm_nxt;
    logic [14:0] dutyEff;
    logic [14:0] cntEff;

    // Fast mode drops bit 14 of both sides of the compare
    always_comb
    begin
        dutyEff = hiFreq ? {1'b0, duty[13:0]} : duty;
        cntEff  = hiFreq ? {1'b0, count[13:0]} : count;
        pwm_nxt = (cntEff < dutyEff);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pwm_r <= 1'b0;
        else
            pwm_r <= pwm_nxt;
    end

    assign pwmOut = pwm_r;

    AST_DUTY_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        (duty == 15'h0000) |=> !pwmOut)
        else $error("channel high with zero duty");
    AST_BIT14_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
        (hiFreq && duty[13:0] == 14'h0000) |=> !pwmOut)
        else $error("bit 14 used in fast mode");

endmodule : ltp_pwm_chan

/* ltp_regs.sv */
// Register set of a chained RGB LED driver: heat reading, overheat
// thresholds, setup byte, channel word, fault flags and PWM drive.
// Assumes command decode, framing and status transmission live outside
// and run on the same clock; adcCode is settled when sensorTick fires.
//
// What this block does
// - Heat read returns 8-bit die code
// - Overheat filter needs one to four samples
// - Flag rises when code exceeds trip level
// - Flag clears only below release level
// - New thresholds wait one full sensor cycle
// - Mode bit picks about 763 Hz/15 or 1526/14
// - Setup bit 6 inverts host clock
// - CRC checked only when enable bit set
// - Sensor rate 19.2 or 2.4 kHz
// - Comm error flags, optionally requests sleep
// - LED fault flags, optionally requests sleep
// - Overheat flags, optionally requests sleep
// - Undervoltage flags, optionally requests sleep
// - Channel word holds red, green, blue thirds
// - Select bit picks night or day current
// - Fast mode ignores duty bit 14
// - Channel write takes effect immediately
// - Setup write replaces whole setup byte
// - Threshold write uses read layout
// - Status readout clears fault flags
`timescale 1ns/1ps
module ltp_regs #(
    parameter int SENS_SLOW_CYC = ltp_pkg::SENS_SLOW_CYC // Slow sensor period
) (
    input  wire logic                clk,        // 25 MHz clock
    input  wire logic                rst_n,      // Async reset, active low
    input  wire ltp_pkg::ltp_cmd_t   cmdIn,      // Decoded register command
    output ltp_pkg::ltp_resp_t       respOut,    // Read answer, one cycle
    input  wire logic                statusRead, // Status response sent
    input  wire logic [7:0]          adcCode,    // Sensor conversion result
    input  wire ltp_pkg::ltp_faults_t faultIn,   // Fault event pulses
    output logic                     sensorTick, // Sensor update strobe
    output logic                     overheatFaultFlag, // Overheat flag
    output logic                     commFaultFlag,     // Comm error flag
    output logic                     ledFaultFlag,      // LED fault flag
    output logic                     uvFaultFlag,       // Undervoltage flag
    output logic                     sleepReq,   // Enter SLEEP pulse
    output logic                     crcCheckEn, // Check message CRC
    output logic                     hostClockPolarityInvert, // Clock inv
    output logic [2:0]               colorPwm,   // R,G,B drive levels
    output logic [2:0]               colorCurrentSel // 1 day, 0 night
);

    localparam int SENS_CW = $clog2(SENS_SLOW_CYC + ltp_pkg::SENS_FAST_CYC);
    localparam logic [SENS_CW-1:0] FAST_MAX =
        SENS_CW'(ltp_pkg::SENS_FAST_CYC - 1);
    localparam logic [SENS_CW-1:0] SLOW_MAX = SENS_CW'(SENS_SLOW_CYC - 1);
    localparam logic [7:0] PWM_TMAX = 8'(ltp_pkg::PWM_TICK_CYC - 1);

    // Register state
    logic [7:0]  setup_r,   setup_nxt;
    logic [23:0] thrAct_r,  thrAct_nxt;
    logic [23:0] thrNew_r,  thrNew_nxt;
    logic        thrPend_r, thrPend_nxt;
    logic        thrArm_r,  thrArm_nxt;
    logic [47:0] chan_r,    chan_nxt;
    logic [7:0]  heat_r,    heat_nxt;
    ltp_pkg::ltp_resp_t resp_r, resp_nxt;
    // Timing state
    logic [SENS_CW-1:0] sensCnt_r, sensCnt_nxt;
    logic [7:0]  tickCnt_r, tickCnt_nxt;
    logic [14:0] pwmCnt_r,  pwmCnt_nxt;
    // Fault state
    logic [2:0]  overCnt_r, overCnt_nxt;
    logic        ot_r, ot_nxt, ce_r, ce_nxt, los_r, los_nxt, uv_r, uv_nxt;
    logic        sleep_r, sleep_nxt;
    logic        otEvt, thrApply, hiFreq;

    // Command predicate used by several groups
    function automatic logic isCmd(input ltp_pkg::ltp_cmd_t c,
                                   input ltp_pkg::ltp_cmd_code_t k);
        isCmd = c.valid && (c.code == k);
    endfunction : isCmd

    assign hiFreq = setup_r[ltp_pkg::SB_PWMF];

    // Register file and read answers
    always_comb
    begin
        setup_nxt   = setup_r;
        thrNew_nxt  = thrNew_r;
        thrPend_nxt = thrPend_r;
        thrArm_nxt  = thrArm_r;
        thrAct_nxt  = thrAct_r;
        chan_nxt    = chan_r;
        heat_nxt    = heat_r;
        resp_nxt    = '0;
        thrApply    = sensorTick && thrPend_r && thrArm_r;
        if (sensorTick)
            heat_nxt = adcCode;
        // Staged thresholds apply on the second tick after the write,
        // so a whole sensor period always passes first
        if (thrApply)
        begin
            thrAct_nxt  = thrNew_r;
            thrPend_nxt = 1'b0;
            thrArm_nxt  = 1'b0;
        end
        else if (sensorTick && thrPend_r)
            thrArm_nxt = 1'b1;
        if (isCmd(cmdIn, ltp_pkg::CMD_WRITE_CONFIG_BYTE))
            setup_nxt = cmdIn.data[7:0];
        if (isCmd(cmdIn, ltp_pkg::CMD_WRITE_OVERHEAT_LIMITS))
        begin
            thrNew_nxt  = cmdIn.data[23:0] & ltp_pkg::TH_MASK;
            thrPend_nxt = 1'b1;
            thrArm_nxt  = 1'b0;   // A rewrite restarts the wait
        end
        if (isCmd(cmdIn, ltp_pkg::CMD_WRITE_CHANNEL_WORD))
            chan_nxt = cmdIn.data;
        if (cmdIn.valid)
        begin
            resp_nxt.valid = 1'b1;
            case (cmdIn.code)
                ltp_pkg::CMD_READ_HEAT:
                    resp_nxt.data = {40'h0000000000, heat_r};
                ltp_pkg::CMD_READ_OVERHEAT_LIMITS:
                    resp_nxt.data = {24'h000000,
                        thrPend_r ? thrNew_r : thrAct_r};
                ltp_pkg::CMD_READ_CONFIG_BYTE:
                    resp_nxt.data = {40'h0000000000, setup_r};
                ltp_pkg::CMD_READ_CHANNEL_WORD:
                    resp_nxt.data = chan_r;
                default:
                    resp_nxt.valid = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            setup_r   <= ltp_pkg::SETUP_RST;
            thrAct_r  <= ltp_pkg::TH_RST;
            thrNew_r  <= ltp_pkg::TH_RST;
            thrPend_r <= 1'b0;
            thrArm_r  <= 1'b0;
            chan_r    <= ltp_pkg::CH_RST;
            heat_r    <= 8'h00;
            resp_r    <= '0;
        end
        else
        begin
            setup_r   <= setup_nxt;
            thrAct_r  <= thrAct_nxt;
            thrNew_r  <= thrNew_nxt;
            thrPend_r <= thrPend_nxt;
            thrArm_r  <= thrArm_nxt;
            chan_r    <= chan_nxt;
            heat_r    <= heat_nxt;
            resp_r    <= resp_nxt;
        end
    end

    // Sensor period divider and shared modulation counter
    always_comb
    begin
        sensorTick  = 1'b0;
        sensCnt_nxt = sensCnt_r + 1'b1;
        if (sensCnt_r >= (setup_r[ltp_pkg::SB_RATE] ? SLOW_MAX : FAST_MAX))
        begin
            sensorTick  = 1'b1;
            sensCnt_nxt = '0;
        end
        tickCnt_nxt = tickCnt_r + 8'h01;
        pwmCnt_nxt  = pwmCnt_r;
        if (tickCnt_r >= PWM_TMAX)
        begin
            tickCnt_nxt = 8'h00;
            // Counter wraps at 2^14 in fast mode: double the frequency
            pwmCnt_nxt = pwmCnt_r + 15'h0001;
            if (hiFreq)
                pwmCnt_nxt[14] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sensCnt_r <= '0;
            tickCnt_r <= 8'h00;
            pwmCnt_r  <= 15'h0000;
        end
        else
        begin
            sensCnt_r <= sensCnt_nxt;
            tickCnt_r <= tickCnt_nxt;
            pwmCnt_r  <= pwmCnt_nxt;
        end
    end

    // Fault flags: a new event beats a same-cycle readout clear
    always_comb
    begin
        overCnt_nxt = overCnt_r;
        otEvt       = 1'b0;
        if (sensorTick)
        begin
            if (adcCode > thrAct_r[ltp_pkg::TH_TRIP_LSB +: 8])
            begin
                if (overCnt_r != 3'h4)
                    overCnt_nxt = overCnt_r + 3'h1;
                otEvt = (overCnt_r ==
                    {1'b0, thrAct_r[ltp_pkg::TH_FILT_LSB +: 2]});
            end
            else
                overCnt_nxt = 3'h0;
        end
        ot_nxt  = ot_r;
        ce_nxt  = ce_r;
        los_nxt = los_r;
        uv_nxt  = uv_r;
        if (statusRead)
        begin
            if (heat_r < thrAct_r[ltp_pkg::TH_REL_LSB +: 8])
                ot_nxt = 1'b0;
            ce_nxt  = 1'b0;
            los_nxt = 1'b0;
            uv_nxt  = 1'b0;
        end
        if (otEvt)
            ot_nxt = 1'b1;
        if (faultIn.comm)
            ce_nxt = 1'b1;
        if (faultIn.led)
            los_nxt = 1'b1;
        if (faultIn.uv)
            uv_nxt = 1'b1;
        sleep_nxt = (faultIn.comm && setup_r[ltp_pkg::SB_CESLP])
                 || (faultIn.led  && setup_r[ltp_pkg::SB_LOSSLP])
                 || (otEvt        && setup_r[ltp_pkg::SB_OTSLP])
                 || (faultIn.uv   && setup_r[ltp_pkg::SB_UVSLP]);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overCnt_r <= 3'h0;
            ot_r      <= 1'b0;
            ce_r      <= 1'b0;
            los_r     <= 1'b0;
            uv_r      <= 1'b0;
            sleep_r   <= 1'b0;
        end
        else
        begin
            overCnt_r <= overCnt_nxt;
            ot_r      <= ot_nxt;
            ce_r      <= ce_nxt;
            los_r     <= los_nxt;
            uv_r      <= uv_nxt;
            sleep_r   <= sleep_nxt;
        end
    end

    // One compare per colour, red on bit 2
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gen_chan
            ltp_pwm_chan u_chan (
                .clk    (clk),
                .rst_n  (rst_n),
                .hiFreq (hiFreq),
                .count  (pwmCnt_r),
                .duty   (chan_r[g*16 +: 15]),
                .pwmOut (colorPwm[g])
            );
            assign colorCurrentSel[g] = chan_r[g*16 + ltp_pkg::CH_ISEL];
        end
    endgenerate

    assign respOut                 = resp_r;
    assign overheatFaultFlag       = ot_r;
    assign commFaultFlag           = ce_r;
    assign ledFaultFlag            = los_r;
    assign uvFaultFlag             = uv_r;
    assign sleepReq                = sleep_r;
    assign crcCheckEn              = setup_r[ltp_pkg::SB_CRCEN];
    assign hostClockPolarityInvert = setup_r[ltp_pkg::SB_CLKINV];

    // Ticks seen since the last threshold write, for checking only
    logic [1:0] wrTicks_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wrTicks_r <= 2'h0;
        else if (isCmd(cmdIn, ltp_pkg::CMD_WRITE_OVERHEAT_LIMITS))
            wrTicks_r <= 2'h0;
        else if (sensorTick && wrTicks_r != 2'h3)
            wrTicks_r <= wrTicks_r + 2'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_HEAT_READ: assert property (
        isCmd(cmdIn, ltp_pkg::CMD_READ_HEAT) && !sensorTick
        |=> respOut.valid && respOut.data[7:0] == heat_r)
        else $error("heat read answer wrong");
    AST_OT_TRIP: assert property (
        otEvt |=> overheatFaultFlag)
        else $error("overheat flag not raised");
    AST_OT_FILTER: assert property (
        sensorTick && !ot_r && overCnt_r < {1'b0, thrAct_r[21:20]}
        |=> !overheatFaultFlag)
        else $error("overheat flag raised inside filter length");
    AST_OT_HOLD: assert property (
        statusRead && ot_r && heat_r >= thrAct_r[15:8] |=> ot_r)
        else $error("overheat flag cleared above release");
    AST_TH_DELAY: assert property (
        thrApply |-> wrTicks_r != 2'h0)
        else $error("threshold applied before a full period");
    AST_SETUP_WR: assert property (
        isCmd(cmdIn, ltp_pkg::CMD_WRITE_CONFIG_BYTE)
        |=> crcCheckEn == $past(cmdIn.data[5])
            && setup_r == $past(cmdIn.data[7:0]))
        else $error("setup write not stored");
    AST_CH_WR: assert property (
        isCmd(cmdIn, ltp_pkg::CMD_WRITE_CHANNEL_WORD)
        |=> colorCurrentSel == {$past(cmdIn.data[47]),
            $past(cmdIn.data[31]), $past(cmdIn.data[15])})
        else $error("channel write not immediate");
    AST_COMM_SLEEP: assert property (
        faultIn.comm && setup_r[3] |=> sleepReq && commFaultFlag)
        else $error("comm fault sleep missing");
    AST_UV_FLAG: assert property (
        faultIn.uv && !setup_r[0] && !faultIn.comm && !faultIn.led
        && !otEvt |=> uvFaultFlag && !sleepReq)
        else $error("undervoltage handling wrong");
    AST_CE_CLEAR: assert property (
        statusRead && !faultIn.comm |=> !commFaultFlag)
        else $error("comm flag not cleared by readout");

    COV_OT_TRIP:  cover property (otEvt ##1 sleepReq);
    COV_TH_APPLY: cover property (thrApply);
    COV_FASTMODE: cover property (hiFreq && colorPwm[2]);

endmodule : ltp_regs

/* ltp_regs_dummy_end.sv */
`timescale 1ns/1ps

/* ltp_host_model.sv */
// Host side model: issues register commands and status readouts.
// Assumes the device takes one command per rising edge with valid high.
`timescale 1ns/1ps
module ltp_host_model (
    input  wire logic               clk,        // 25 MHz clock
    output ltp_pkg::ltp_cmd_t       cmdOut,     // Command to device
    output logic                    statusRead, // Status sent strobe
    input  wire ltp_pkg::ltp_resp_t respIn      // Device answer
);
    // Idle at time zero
    initial
    begin
        cmdOut     = '0;
        statusRead = 1'b0;
    end

    // One command; payload scrambled after, so stale data never helps
    task automatic send(input ltp_pkg::ltp_cmd_code_t code,
                        input logic [47:0]            data);
        @(posedge clk);
        #1;
        cmdOut = '{valid: 1'b1, code: code, data: data};
        @(posedge clk);
        #1;
        cmdOut.valid = 1'b0;
        cmdOut.data  = ~data;
    endtask : send

    // Answer stands one cycle only, so capture it right here
    task automatic fetch(input  ltp_pkg::ltp_cmd_code_t code,
                         output logic [48:0]            resp);
        send(code, 48'h000000000000);
        resp = respIn;
    endtask : fetch

    // Strobe marks a status response just sent
    task automatic status;
        @(posedge clk);
        #1;
        statusRead = 1'b1;
        @(posedge clk);
        #1;
        statusRead = 1'b0;
    endtask : status
endmodule : ltp_host_model

/* tb_ltp_regs.sv */
// Self-checking bench for the LED register set.
// Assumes the host model owns commands; the bench plays sensor and faults.
`timescale 1ns/1ps
module tb_ltp_regs;
    localparam int SLOW = 40;
    logic                 clk, rst_n, statusRead, sensorTick, sleepReq;
    logic                 overheatFaultFlag, commFaultFlag, ledFaultFlag;
    logic                 uvFaultFlag, crcCheckEn, hostClockPolarityInvert;
    ltp_pkg::ltp_cmd_t    cmdIn;
    ltp_pkg::ltp_resp_t   respOut;
    ltp_pkg::ltp_faults_t faultIn;
    logic [7:0]           adcCode;
    logic [2:0]           colorPwm, colorCurrentSel;
    logic [48:0]          resp;
    int n_fail, comparisons, cycles, sleepCnt, n0, hiR, hiG, hiB;

    ltp_regs #(.SENS_SLOW_CYC(SLOW)) dut (
        .clk(clk), .rst_n(rst_n), .cmdIn(cmdIn), .respOut(respOut),
        .statusRead(statusRead), .adcCode(adcCode), .faultIn(faultIn),
        .sensorTick(sensorTick), .overheatFaultFlag(overheatFaultFlag),
        .commFaultFlag(commFaultFlag), .ledFaultFlag(ledFaultFlag),
        .uvFaultFlag(uvFaultFlag), .sleepReq(sleepReq),
        .crcCheckEn(crcCheckEn),
        .hostClockPolarityInvert(hostClockPolarityInvert),
        .colorPwm(colorPwm), .colorCurrentSel(colorCurrentSel));

    ltp_host_model host (.clk(clk), .cmdOut(cmdIn),
        .statusRead(statusRead), .respIn(respOut));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Sleep pulses and hang guard sampled mid-cycle to dodge edge races
    always @(negedge clk)
    begin
        cycles++;
        if (sleepReq === 1'b1)
            sleepCnt++;
        if (cycles == 90000)
        begin
            n_fail++;
            final_report();
        end
    end

    task automatic chk(input logic [48:0] got, input logic [48:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Returns just after the edge on which the sensor strobe was seen
    task automatic waitTick;
        int g;
        g = 0;
        while (sensorTick !== 1'b1 && g < 2000)
        begin
            @(negedge clk);
            g++;
        end
        @(posedge clk);
        #1;
    endtask : waitTick

    // Period is fixed by the mode, so any full window gives exact counts
    task automatic countHigh(input int len);
        hiR = 0;
        hiG = 0;
        hiB = 0;
        repeat (len)
        begin
            @(negedge clk);
            hiR += (colorPwm[2] === 1'b1);
            hiG += (colorPwm[1] === 1'b1);
            hiB += (colorPwm[0] === 1'b1);
        end
    endtask : countHigh

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    initial
    begin
        rst_n = 1'b0;
        adcCode = 8'h00;
        faultIn = '0;
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        // Reset contents and a refused command
        host.fetch(ltp_pkg::CMD_READ_CONFIG_BYTE, resp);
        chk(resp, {1'b1, 48'h000000000013});
        host.fetch(ltp_pkg::CMD_READ_OVERHEAT_LIMITS, resp);
        chk(resp, {1'b1, 48'h00000030E6F0});
        host.fetch(ltp_pkg::CMD_READ_CHANNEL_WORD, resp);
        chk(resp, {1'b1, 48'h000000000000});
        host.fetch(ltp_pkg::CMD_NONE, resp);
        chk(49'(resp[48]), 49'h0);
        // CRC and clock inversion on, then both off again
        host.send(ltp_pkg::CMD_WRITE_CONFIG_BYTE, 48'h73);
        host.fetch(ltp_pkg::CMD_READ_CONFIG_BYTE, resp);
        chk(resp, {1'b1, 48'h000000000073});
        chk(49'(crcCheckEn), 49'h1);
        chk(49'(hostClockPolarityInvert), 49'h1);
        host.send(ltp_pkg::CMD_WRITE_CONFIG_BYTE, 48'h13);
        @(posedge clk);
        #1;
        chk(49'(crcCheckEn), 49'h0);
        chk(49'(hostClockPolarityInvert), 49'h0);
        // Heat capture
        adcCode = 8'hA5;
        waitTick();
        host.fetch(ltp_pkg::CMD_READ_HEAT, resp);
        chk(resp, {1'b1, 48'h0000000000A5});
        // Channel word, slow mode
        host.send(ltp_pkg::CMD_WRITE_CHANNEL_WORD, 48'h80040000FFFF);
        chk(49'(colorCurrentSel), 49'h5);
        host.fetch(ltp_pkg::CMD_READ_CHANNEL_WORD, resp);
        chk(resp, {1'b1, 48'h80040000FFFF});
        countHigh(32768);
        chk(49'(hiR), 49'h4);
        chk(49'(hiG), 49'h0);
        chk(49'(hiB), 49'h7FFF);
        // Fast mode: duty bit 14 dropped
        host.send(ltp_pkg::CMD_WRITE_CONFIG_BYTE, 48'h93);
        host.send(ltp_pkg::CMD_WRITE_CHANNEL_WORD, 48'hC00440007FFF);
        chk(49'(colorCurrentSel), 49'h4);
        repeat (16400) @(posedge clk);
        countHigh(16384);
        chk(49'(hiR), 49'h4);
        chk(49'(hiG), 49'h0);
        chk(49'(hiB), 49'h3FFF);
        host.send(ltp_pkg::CMD_WRITE_CONFIG_BYTE, 48'h13);
        // Overheat: filter two samples, release 80, trip C0
        host.send(ltp_pkg::CMD_WRITE_OVERHEAT_LIMITS, 48'h1080C0);
        host.fetch(ltp_pkg::CMD_READ_OVERHEAT_LIMITS, resp);
        chk(resp, {1'b1, 48'h0000001080C0});
        adcCode = 8'hC1;
        n0 = sleepCnt;
        waitTick();
        waitTick();
        chk(49'(overheatFaultFlag), 49'h0);
        waitTick();
        waitTick();
        @(posedge clk);
        #1;
        chk(49'(overheatFaultFlag), 49'h1);
        chk(49'(sleepCnt - n0), 49'h1);
        host.status();
        @(posedge clk);
        #1;
        chk(49'(overheatFaultFlag), 49'h1);
        adcCode = 8'h7F;
        waitTick();
        host.status();
        @(posedge clk);
        #1;
        chk(49'(overheatFaultFlag), 49'h0);
        // Comm, LED and undervoltage faults under both sleep settings
        for (int s = 0; s < 2; s++)
        begin
            host.send(ltp_pkg::CMD_WRITE_CONFIG_BYTE, s ? 48'h1C : 48'h13);
            for (int f = 0; f < 3; f++)
            begin
                n0 = sleepCnt;
                @(posedge clk);
                #1;
                faultIn = ltp_pkg::ltp_faults_t'(3'b100 >> f);
                @(posedge clk);
                #1;
                faultIn = '0;
                repeat (2) @(posedge clk);
                #1;
                chk(49'({commFaultFlag, ledFaultFlag, uvFaultFlag}),
                    49'(3'b100 >> f));
                chk(49'(sleepCnt - n0),
                    49'(s ? (f < 2) : (f == 2)));
                host.status();
                @(posedge clk);
                #1;
                chk(49'({commFaultFlag, ledFaultFlag, uvFaultFlag}),
                    49'h0);
            end
        end
        // Sensor period under both rate settings
        for (int r = 0; r < 2; r++)
        begin
            host.send(ltp_pkg::CMD_WRITE_CONFIG_BYTE, r ? 48'h13 : 48'h03);
            waitTick();
            n0 = cycles;
            waitTick();
            chk(49'(cycles - n0),
                r ? 49'(SLOW) : 49'(ltp_pkg::SENS_FAST_CYC));
        end
        final_report();
    end
endmodule : tb_ltp_regs
